// File: design/pcfr_core.sv
// stream port, runtime controls and stage chain of the cfr core
`timescale 1ns/10ps
module pcfr_core import pcfr_pkg::*; #(
  parameter int N_STG    = N_STG_DEF,
  parameter int N_ANT    = N_ANT_DEF,
  parameter int N_CE     = N_CE_DEF,
  parameter int FOLD     = FOLD_DEF,
  parameter bit IQ_MUXED = 1'b0,
  parameter bit RT_CLIP  = 1'b0,
  parameter bit GAIN_EN  = 1'b0
) (
  input  wire logic               sys_clk,
  input  wire logic               rst_b,
  input  wire logic               hold_enable,
  input  wire logic               input_valid_strobe,
  input  wire logic               input_i_marker,
  output logic                    ready_for_input,
  input  wire logic signed [17:0] in_inphase_ant0,
  input  wire logic signed [17:0] in_inphase_ant1,
  input  wire logic signed [17:0] in_inphase_ant2,
  input  wire logic signed [17:0] in_inphase_ant3,
  input  wire logic signed [17:0] in_quadrature_ant0,
  input  wire logic signed [17:0] in_quadrature_ant1,
  input  wire logic signed [17:0] in_quadrature_ant2,
  input  wire logic signed [17:0] in_quadrature_ant3,
  input  wire logic signed [17:0] in_muxed_ant0,
  input  wire logic signed [17:0] in_muxed_ant1,
  input  wire logic signed [17:0] in_muxed_ant2,
  input  wire logic signed [17:0] in_muxed_ant3,
  output logic                    output_valid_strobe,
  output logic                    output_i_marker,
  output logic signed [17:0]      res_inphase_ant0,
  output logic signed [17:0]      res_inphase_ant1,
  output logic signed [17:0]      res_inphase_ant2,
  output logic signed [17:0]      res_inphase_ant3,
  output logic signed [17:0]      res_quadrature_ant0,
  output logic signed [17:0]      res_quadrature_ant1,
  output logic signed [17:0]      res_quadrature_ant2,
  output logic signed [17:0]      res_quadrature_ant3,
  output logic signed [17:0]      res_muxed_ant0,
  output logic signed [17:0]      res_muxed_ant1,
  output logic signed [17:0]      res_muxed_ant2,
  output logic signed [17:0]      res_muxed_ant3,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic [31:0]             hrdata,
  output logic                    hresp
);
  localparam int STG_LAT = PULSE_HALF + 1;
  localparam int LAT     = N_STG * STG_LAT + 3;
  localparam bit PAIRED  = (FOLD == 2) && !IQ_MUXED;

  // --------------------------------------------------------------
  // register slave
  // --------------------------------------------------------------
  logic [17:0]      clip_ff;
  logic [4:0]       span_ff;
  logic [1:0]       set_ff;
  logic [15:0]      scale_ff;
  logic [CNT_W-1:0] in_cnt_ff;
  logic [CNT_W-1:0] out_cnt_ff;
  logic             wr_ff;
  logic [7:0]       wa_ff;
  logic [7:0]       ra_ff;
  logic             ap_take;
  logic             span_ok;
  logic [17:0]      clip_lvl;

  // zero-wait slave: address phase captured, write done in data phase
  assign ap_take   = hsel && htrans[1] && hready;
  assign span_ok   = hwdata[4:0] >= SPAN_MIN && hwdata[4:0] <= SPAN_MAX;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign clip_lvl  = RT_CLIP ? clip_ff : FIXED_CLIP;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ff <= 1'b0;
      wa_ff <= 8'h00;
      ra_ff <= 8'h00;
    end else if (hready) begin
      wr_ff <= ap_take && hwrite;
      wa_ff <= haddr[7:0];
      ra_ff <= haddr[7:0];
    end
  end

  // out-of-range span and zero clip level writes are dropped
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      clip_ff  <= FIXED_CLIP;
      span_ff  <= SPAN_RST;
      set_ff   <= SET_RST;
      scale_ff <= SCALE_UNITY;
    end else if (wr_ff) begin
      if (wa_ff == REG_CLIP && hwdata[17:0] != 18'h0) clip_ff <= hwdata[17:0];
      if (wa_ff == REG_SPAN && span_ok) span_ff <= hwdata[4:0];
      if (wa_ff == REG_SET) set_ff <= hwdata[1:0];
      if (wa_ff == REG_SCALE) scale_ff <= hwdata[15:0];
    end
  end

  // read mux of stored values; unmapped reads return zero
  assign hrdata = (ra_ff == REG_CLIP)    ? {14'h0, clip_ff} :
                  (ra_ff == REG_SPAN)    ? {27'h0, span_ff} :
                  (ra_ff == REG_SET)     ? {30'h0, set_ff} :
                  (ra_ff == REG_SCALE)   ? {16'h0, scale_ff} :
                  (ra_ff == REG_IN_CNT)  ? in_cnt_ff :
                  (ra_ff == REG_OUT_CNT) ? out_cnt_ff : 32'h0;

  // --------------------------------------------------------------
  // input side
  // --------------------------------------------------------------
  logic signed [17:0] in_i [0:3];
  logic signed [17:0] in_q [0:3];
  logic signed [17:0] in_m [0:3];
  logic signed [17:0] fe_i_ff [0:3];
  logic signed [17:0] fe_q_ff [0:3];
  logic signed [17:0] il_ff   [0:3];
  logic               fe_v_ff;
  logic               rdy_ff;
  logic               take;
  logic               pair_take;

  assign in_i = '{in_inphase_ant0, in_inphase_ant1, in_inphase_ant2, in_inphase_ant3};
  assign in_q = '{in_quadrature_ant0, in_quadrature_ant1, in_quadrature_ant2,
                  in_quadrature_ant3};
  assign in_m = '{in_muxed_ant0, in_muxed_ant1, in_muxed_ant2, in_muxed_ant3};

  // only the paired factor-2 mode ever throttles the source
  assign ready_for_input = PAIRED ? rdy_ff : 1'b1;
  assign take            = input_valid_strobe && ready_for_input && hold_enable;
  // a muxed pair completes on its Q sample
  assign pair_take       = IQ_MUXED ? take && !input_i_marker : take;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int a = 0; a < 4; a++) begin
        fe_i_ff[a] <= 18'sh0;
        fe_q_ff[a] <= 18'sh0;
        il_ff[a]   <= 18'sh0;
      end
      fe_v_ff <= 1'b0;
      rdy_ff  <= 1'b1;
    end else if (hold_enable) begin
      rdy_ff  <= !take;
      fe_v_ff <= pair_take;
      for (int a = 0; a < 4; a++) begin
        if (IQ_MUXED && take && input_i_marker) il_ff[a] <= in_m[a];
        if (pair_take) begin
          fe_i_ff[a] <= IQ_MUXED ? il_ff[a] : in_i[a];
          fe_q_ff[a] <= IQ_MUXED ? in_m[a] : in_q[a];
        end
      end
    end
  end

  // --------------------------------------------------------------
  // stage chain per antenna
  // --------------------------------------------------------------
  logic signed [17:0] st_i [0:3][0:N_STG];
  logic signed [17:0] st_q [0:3][0:N_STG];
  logic               st_v [0:3][0:N_STG];

  for (genvar a = 0; a < 4; a++) begin : g_ant
    assign st_i[a][0] = fe_i_ff[a];
    assign st_q[a][0] = fe_q_ff[a];
    assign st_v[a][0] = fe_v_ff;
    for (genvar s = 0; s < N_STG; s++) begin : g_stg
      if (a < N_ANT) begin : g_on
        pcfr_stage #(.N_CE(N_CE)) u_stage (
          .sys_clk     (sys_clk),
          .rst_b       (rst_b),
          .hold_enable (hold_enable),
          .vld_in      (st_v[a][s]),
          .i_in        (st_i[a][s]),
          .q_in        (st_q[a][s]),
          .clip_lvl    (clip_lvl),
          .span        (span_ff),
          .bank        (set_ff),
          .vld_out     (st_v[a][s+1]),
          .i_out       (st_i[a][s+1]),
          .q_out       (st_q[a][s+1])
        );
      end else begin : g_off
        assign st_v[a][s+1] = 1'b0;
        assign st_i[a][s+1] = 18'sh0;
        assign st_q[a][s+1] = 18'sh0;
      end
    end
  end

  // --------------------------------------------------------------
  // final gain and output side
  // --------------------------------------------------------------
  logic signed [17:0] gn_i_ff  [0:3];
  logic signed [17:0] gn_q_ff  [0:3];
  logic signed [17:0] ro_i_ff  [0:3];
  logic signed [17:0] ro_q_ff  [0:3];
  logic signed [17:0] ro_m_ff  [0:3];
  logic               gn_v_ff;
  logic               ov_ff;
  logic               om_ff;
  logic               qpend_ff;

  // gain stage kept as a register even when off, so latency never moves
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int a = 0; a < 4; a++) begin
        gn_i_ff[a] <= 18'sh0;
        gn_q_ff[a] <= 18'sh0;
      end
      gn_v_ff <= 1'b0;
    end else if (hold_enable) begin
      gn_v_ff <= st_v[0][N_STG];
      for (int a = 0; a < 4; a++) begin
        gn_i_ff[a] <= GAIN_EN ? sat_data((40'(st_i[a][N_STG]) * 40'($signed(scale_ff)))
                                >>> SCALE_FRAC) : st_i[a][N_STG];
        gn_q_ff[a] <= GAIN_EN ? sat_data((40'(st_q[a][N_STG]) * 40'($signed(scale_ff)))
                                >>> SCALE_FRAC) : st_q[a][N_STG];
      end
    end
  end

  // muxed mode sends I with the marker, then the held Q next cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int a = 0; a < 4; a++) begin
        ro_i_ff[a] <= 18'sh0;
        ro_q_ff[a] <= 18'sh0;
        ro_m_ff[a] <= 18'sh0;
      end
      ov_ff    <= 1'b0;
      om_ff    <= 1'b0;
      qpend_ff <= 1'b0;
    end else if (hold_enable) begin
      ov_ff    <= gn_v_ff || (IQ_MUXED && qpend_ff);
      om_ff    <= gn_v_ff;
      qpend_ff <= IQ_MUXED && gn_v_ff;
      for (int a = 0; a < 4; a++) begin
        if (gn_v_ff) begin
          ro_i_ff[a] <= gn_i_ff[a];
          ro_q_ff[a] <= gn_q_ff[a];
          ro_m_ff[a] <= gn_i_ff[a];
        end else if (qpend_ff) begin
          ro_m_ff[a] <= ro_q_ff[a];
        end
      end
    end
  end

  // event counters shown to software
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      in_cnt_ff  <= '0;
      out_cnt_ff <= '0;
    end else if (hold_enable) begin
      if (pair_take) in_cnt_ff <= in_cnt_ff + 32'h1;
      if (gn_v_ff) out_cnt_ff <= out_cnt_ff + 32'h1;
    end
  end

  assign output_valid_strobe = ov_ff;
  assign output_i_marker     = om_ff;
  assign res_inphase_ant0    = ro_i_ff[0];
  assign res_inphase_ant1    = ro_i_ff[1];
  assign res_inphase_ant2    = ro_i_ff[2];
  assign res_inphase_ant3    = ro_i_ff[3];
  assign res_quadrature_ant0 = ro_q_ff[0];
  assign res_quadrature_ant1 = ro_q_ff[1];
  assign res_quadrature_ant2 = ro_q_ff[2];
  assign res_quadrature_ant3 = ro_q_ff[3];
  assign res_muxed_ant0      = ro_m_ff[0];
  assign res_muxed_ant1      = ro_m_ff[1];
  assign res_muxed_ant2      = ro_m_ff[2];
  assign res_muxed_ant3      = ro_m_ff[3];

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  logic [LAT-1:0] chk_sr_ff;

  // independent count of enabled cycles since each accepted pair
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) chk_sr_ff <= '0;
    else if (hold_enable) chk_sr_ff <= {chk_sr_ff[LAT-2:0], pair_take};
  end

  property p_rdy_high;
    @(posedge sys_clk) disable iff (!rst_b) !PAIRED |-> ready_for_input;
  endproperty
  a_rdy_high: assert property (p_rdy_high) else $error("ready dropped");

  property p_pair_gap;
    @(posedge sys_clk) disable iff (!rst_b) PAIRED && take |=> !ready_for_input;
  endproperty
  a_pair_gap: assert property (p_pair_gap) else $error("pair too soon");

  property p_latency;
    @(posedge sys_clk) disable iff (!rst_b) output_i_marker == chk_sr_ff[LAT-1];
  endproperty
  a_latency: assert property (p_latency) else $error("latency wrong");

  property p_valid_par;
    @(posedge sys_clk) disable iff (!rst_b)
      !IQ_MUXED |-> output_valid_strobe == output_i_marker;
  endproperty
  a_valid_par: assert property (p_valid_par) else $error("marker off I");

  property p_mux_q;
    @(posedge sys_clk) disable iff (!rst_b)
      IQ_MUXED && output_i_marker && hold_enable |=> output_valid_strobe && !output_i_marker;
  endproperty
  a_mux_q: assert property (p_mux_q) else $error("Q not after I");

  property p_valid_src;
    @(posedge sys_clk) disable iff (!rst_b)
      output_valid_strobe |-> output_i_marker || (IQ_MUXED && $past(output_i_marker));
  endproperty
  a_valid_src: assert property (p_valid_src) else $error("stray valid");

  property p_freeze;
    @(posedge sys_clk) disable iff (!rst_b)
      !hold_enable |=> $stable(output_valid_strobe) && $stable(in_cnt_ff);
  endproperty
  a_freeze: assert property (p_freeze) else $error("moved in hold");

  property p_span_rng;
    @(posedge sys_clk) disable iff (!rst_b)
      span_ff >= SPAN_MIN && span_ff <= SPAN_MAX;
  endproperty
  a_span_rng: assert property (p_span_rng) else $error("span out of range");

  property p_clip_fixed;
    @(posedge sys_clk) disable iff (!rst_b) !RT_CLIP |-> clip_lvl == 18'd73707;
  endproperty
  a_clip_fixed: assert property (p_clip_fixed) else $error("clip level moved");
endmodule // pcfr_core

// File: design/pcfr_pkg.sv
// constants and helpers for the peak-cancellation stream port
// Operation
// - ready_for_input high whenever the core can take a sample.
// - output_valid_strobe high exactly when result ports carry valid data.
// - output_i_marker flags the cycle the I part is presented.
// - factor 1: ready always high, one I/Q pair in and out per clock.
// - factor 2 parallel: at most one pair every two clocks.
// - factor 2 muxed: ready high, I and Q alternate, marker on I.
// - pulse filter is odd length symmetric, half coefficients stored.
// - one to three cascaded stages, default one.
// - one to four antenna paths, default one.
// - optional final gain after last stage, absent by default.
// - clip engine count is a build option, default four.
// - fixed clip level 1..262143, default 73707, when runtime level off.
// - five-bit search span, only 3 to 31 valid.
// - two-bit pulse set choice selects bank 0 to 3.
// - final scale is signed 16.13, 8192 is unity.
// - hold_enable low freezes stream state and ignores stream inputs; bus register writes still land.
package pcfr_pkg;
  localparam int          DATA_W      = 18;
  localparam int          CLIP_W      = 18;
  localparam int          SPAN_W      = 5;
  localparam int          SET_W       = 2;
  localparam int          SCALE_W     = 16;
  localparam int          SCALE_FRAC  = 13;
  localparam int          COEF_W      = 16;
  localparam int          COEF_FRAC   = 14;
  localparam int          PULSE_TAPS  = 5;
  localparam int          PULSE_HALF  = 3;
  localparam int          N_STG_DEF   = 1;
  localparam int          N_ANT_DEF   = 1;
  localparam int          N_CE_DEF    = 4;
  localparam int          FOLD_DEF    = 1;
  localparam int          CNT_W       = 32;
  localparam logic [17:0] FIXED_CLIP  = 18'h11feb;
  localparam logic [4:0]  SPAN_MIN    = 5'h03;
  localparam logic [4:0]  SPAN_MAX    = 5'h1f;
  localparam logic [4:0]  SPAN_RST    = 5'h09;
  localparam logic [15:0] SCALE_UNITY = 16'h2000;
  localparam logic [1:0]  SET_RST     = 2'h0;
  // register byte offsets
  localparam logic [7:0]  REG_CLIP    = 8'h00;
  localparam logic [7:0]  REG_SPAN    = 8'h04;
  localparam logic [7:0]  REG_SET     = 8'h08;
  localparam logic [7:0]  REG_SCALE   = 8'h0c;
  localparam logic [7:0]  REG_IN_CNT  = 8'h10;
  localparam logic [7:0]  REG_OUT_CNT = 8'h14;
  // half coefficient banks: outer tap first, centre tap last
  localparam logic signed [15:0] COEF_TBL [0:3][0:2] = '{
    '{16'h0400, 16'h1000, 16'h4000},
    '{16'h0200, 16'h0c00, 16'h4000},
    '{16'h0000, 16'h0800, 16'h4000},
    '{16'hfe00, 16'h1400, 16'h4000}};

  // saturate a wide signed value into the data width
  function automatic logic signed [17:0] sat_data(input logic signed [39:0] v);
    if (v > 40'sh1ffff) sat_data = 18'sh1ffff;
    else if (v < -40'sh20000) sat_data = -18'sh20000;
    else sat_data = v[17:0];
  endfunction

  // part of a component that exceeds the clip level
  function automatic logic signed [17:0] clip_err(input logic signed [17:0] x,
                                                 input logic [17:0] th);
    logic signed [19:0] xs;
    logic signed [19:0] ts;
    xs = 20'(x);
    ts = {2'b00, th};
    if (xs > ts) clip_err = 18'(xs - ts);
    else if (xs < -ts) clip_err = 18'(xs + ts);
    else clip_err = 18'sh0;
  endfunction
endpackage

// File: design/pcfr_stage.sv
// one cancellation stage for one antenna
`timescale 1ns/10ps
module pcfr_stage import pcfr_pkg::*; #(
  parameter int N_CE = N_CE_DEF
) (
  input  wire logic               sys_clk,
  input  wire logic               rst_b,
  input  wire logic               hold_enable,
  input  wire logic               vld_in,
  input  wire logic signed [17:0] i_in,
  input  wire logic signed [17:0] q_in,
  input  wire logic [17:0]        clip_lvl,
  input  wire logic [4:0]         span,
  input  wire logic [1:0]         bank,
  output logic                    vld_out,
  output logic signed [17:0]      i_out,
  output logic signed [17:0]      q_out
);
  localparam int C = PULSE_HALF - 1;

  logic signed [17:0] dl_i_ff [0:PULSE_TAPS-1];
  logic signed [17:0] dl_q_ff [0:PULSE_TAPS-1];
  logic signed [17:0] x_i_ff  [0:C];
  logic signed [17:0] x_q_ff  [0:C];
  logic [PULSE_TAPS-1:0] ev_ff;
  logic [C:0]            v_ff;
  logic [4:0]            cool_ff;
  logic                  vo_ff;
  logic signed [17:0]    io_ff;
  logic signed [17:0]    qo_ff;
  logic signed [17:0]    e_i;
  logic signed [17:0]    e_q;
  logic                  ev;
  logic [3:0]            busy;
  logic signed [39:0]    acc_i;
  logic signed [39:0]    acc_q;

  // engines in use = pulses still inside the filter span
  always_comb begin
    busy = 4'h0;
    for (int k = 0; k < PULSE_TAPS; k++) busy = busy + 4'(ev_ff[k]);
  end

  assign e_i = clip_err(i_in, clip_lvl);
  assign e_q = clip_err(q_in, clip_lvl);
  // a new pulse needs a free engine and an elapsed search window
  assign ev = vld_in && (e_i != 18'sh0 || e_q != 18'sh0) && cool_ff == 5'h00
              && 32'(busy) < N_CE;

  // symmetric pre-add cuts the multiplies per bank from five to three
  always_comb begin
    acc_i = 40'(COEF_TBL[bank][C]) * 40'(dl_i_ff[C]);
    acc_q = 40'(COEF_TBL[bank][C]) * 40'(dl_q_ff[C]);
    for (int k = 0; k < C; k++) begin
      acc_i = acc_i + 40'(COEF_TBL[bank][k]) *
              (40'(dl_i_ff[k]) + 40'(dl_i_ff[PULSE_TAPS-1-k]));
      acc_q = acc_q + 40'(COEF_TBL[bank][k]) *
              (40'(dl_q_ff[k]) + 40'(dl_q_ff[PULSE_TAPS-1-k]));
    end
  end

  // everything shifts once per enabled cycle, so latency is fixed
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int k = 0; k < PULSE_TAPS; k++) begin
        dl_i_ff[k] <= 18'sh0;
        dl_q_ff[k] <= 18'sh0;
      end
      for (int k = 0; k <= C; k++) begin
        x_i_ff[k] <= 18'sh0;
        x_q_ff[k] <= 18'sh0;
      end
      ev_ff   <= '0;
      v_ff    <= '0;
      cool_ff <= 5'h00;
      vo_ff   <= 1'b0;
      io_ff   <= 18'sh0;
      qo_ff   <= 18'sh0;
    end else if (hold_enable) begin
      dl_i_ff[0] <= ev ? e_i : 18'sh0;
      dl_q_ff[0] <= ev ? e_q : 18'sh0;
      for (int k = 1; k < PULSE_TAPS; k++) begin
        dl_i_ff[k] <= dl_i_ff[k-1];
        dl_q_ff[k] <= dl_q_ff[k-1];
      end
      x_i_ff[0] <= i_in;
      x_q_ff[0] <= q_in;
      for (int k = 1; k <= C; k++) begin
        x_i_ff[k] <= x_i_ff[k-1];
        x_q_ff[k] <= x_q_ff[k-1];
      end
      ev_ff   <= {ev_ff[PULSE_TAPS-2:0], ev};
      v_ff    <= {v_ff[C-1:0], vld_in};
      cool_ff <= ev ? span - 5'h01 : (cool_ff != 5'h00 ? cool_ff - 5'h01 : 5'h00);
      vo_ff   <= v_ff[C];
      io_ff   <= sat_data(40'(x_i_ff[C]) - (acc_i >>> COEF_FRAC));
      qo_ff   <= sat_data(40'(x_q_ff[C]) - (acc_q >>> COEF_FRAC));
    end
  end

  assign vld_out = vo_ff;
  assign i_out   = io_ff;
  assign q_out   = qo_ff;
endmodule // pcfr_stage

// File: sim/pcfr_src.sv
// upstream sample source model for the cfr stream port
`timescale 1ns/10ps
module pcfr_src (
  input  wire logic          sys_clk,
  input  wire logic          rst_b,
  input  wire logic          ready_for_input,
  input  wire logic          hold_enable,
  input  wire logic          go,
  input  wire logic [7:0]    n,
  output logic               input_valid_strobe,
  output logic               input_i_marker,
  output logic signed [17:0] in_i,
  output logic signed [17:0] in_q
);
  logic [7:0]         rem_ff;
  logic [17:0]        k_ff;
  logic signed [17:0] v;
  // small values stay far under the clip level, so no peak is cut
  assign v = 18'(k_ff * 37 + 5);
  assign input_valid_strobe = (rem_ff != 8'h00); // held with data until taken
  assign input_i_marker = input_valid_strobe;    // every pair carries its i part
  // idle lines show the inverse so stale data never passes for live
  assign in_i = input_valid_strobe ? v : ~v;
  assign in_q = input_valid_strobe ? -v : v;
  // advance only on a real take
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rem_ff <= 8'h00;
      k_ff <= 18'h00000;
    end else if (go) begin
      rem_ff <= n;
    end else if (input_valid_strobe && ready_for_input && hold_enable) begin
      rem_ff <= rem_ff - 8'h01;
      k_ff <= k_ff + 18'h00001;
    end
  end
endmodule // pcfr_src

// File: sim/tb_top.sv
// self-checking bench for the cfr stream port and its registers
`timescale 1ns/10ps
module tb_top;
  localparam int LAT = 7;
  logic sys_clk, rst_b, hold_enable, go, hsel, hwrite, hreadyout, hresp;
  logic vld, mrk, rdy, ovld, omrk;
  logic [7:0] n;
  logic signed [17:0] si, sq, ri, rq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int num_errors, samples_checked, cyc, nexp;
  int tq[$];
  logic [31:0] rd;
  pcfr_src src_u (.sys_clk(sys_clk), .rst_b(rst_b), .ready_for_input(rdy),
    .hold_enable(hold_enable), .go(go), .n(n), .input_valid_strobe(vld),
    .input_i_marker(mrk), .in_i(si), .in_q(sq));
  pcfr_core dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .hold_enable(hold_enable),
    .input_valid_strobe(vld), .input_i_marker(mrk), .ready_for_input(rdy),
    .in_inphase_ant0(si), .in_inphase_ant1(si), .in_inphase_ant2(si), .in_inphase_ant3(si),
    .in_quadrature_ant0(sq), .in_quadrature_ant1(sq), .in_quadrature_ant2(sq),
    .in_quadrature_ant3(sq), .in_muxed_ant0(si), .in_muxed_ant1(si), .in_muxed_ant2(si),
    .in_muxed_ant3(sq), .output_valid_strobe(ovld), .output_i_marker(omrk),
    .res_inphase_ant0(ri), .res_inphase_ant1(), .res_inphase_ant2(), .res_inphase_ant3(),
    .res_quadrature_ant0(rq), .res_quadrature_ant1(), .res_quadrature_ant2(),
    .res_quadrature_ant3(), .res_muxed_ant0(), .res_muxed_ant1(), .res_muxed_ant2(),
    .res_muxed_ant3(), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input bit ok, input string m);
    samples_checked++;
    if (!ok) begin
      num_errors++;
      $display("mismatch t=%0t %s", $time, m);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // bounded wait for hready; a hang ends the run
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      chk(0, "bus hang");
      summarize();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic send_wait(input logic [7:0] cnt, input int tgt);
    int k;
    // a zero count must not restart the source over samples still pending
    if (cnt != 8'h00) go <= 1'b1;
    n <= cnt;
    @(posedge sys_clk);
    go <= 1'b0;
    for (k = 0; k < 400 && nexp < tgt; k++) @(posedge sys_clk);
    chk(nexp == tgt && tq.size() == 0, "output count");
    if (k >= 400) summarize();
  endtask
  // ----------------------------------------------------------------
  // output monitor, counts only enabled edges
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst_b && hold_enable) begin
      cyc = cyc + 1;
      if (vld && rdy) tq.push_back(cyc);
      if (rdy !== 1'b1) chk(0, "ready low");
      if (ovld === 1'b1) begin
        chk(omrk === 1'b1 && tq.size() > 0 && cyc - tq.pop_front() == LAT, "timing");
        chk(ri === 18'(nexp * 37 + 5) && rq === -18'(nexp * 37 + 5), "data");
        nexp++;
      end else if (omrk === 1'b1) chk(0, "marker alone");
    end
  end
  // ----------------------------------------------------------------
  // clock, reset and scenarios
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    {rst_b, go, hsel, hwrite, htrans, haddr, hwdata, n, cyc, nexp} = '0;
    hold_enable = 1'b1;
    hsize = 3'h2;
    num_errors = 0;
    samples_checked = 0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    bus(1'b0, 8'h00, 32'h0);
    chk(rd === 32'd73707, "clip reset");
    bus(1'b0, 8'h0c, 32'h0);
    chk(rd === 32'h00002000, "scale reset");
    bus(1'b1, 8'h04, 32'h2);
    bus(1'b0, 8'h04, 32'h0);
    chk(rd === 32'h9, "span low refused");
    bus(1'b1, 8'h04, 32'h3);
    bus(1'b0, 8'h04, 32'h0);
    chk(rd === 32'h3, "span min");
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, 8'h08, 32'(s));
      bus(1'b0, 8'h08, 32'h0);
      chk(rd === 32'(s), "set choice");
    end
    bus(1'b0, 8'h20, 32'h0);
    chk(rd === 32'h0, "unmapped");
    send_wait(8'd20, 20);
    go <= 1'b1;
    n <= 8'd6;
    @(posedge sys_clk);
    go <= 1'b0;
    @(posedge sys_clk);
    hold_enable <= 1'b0;
    repeat (6) @(posedge sys_clk);
    hold_enable <= 1'b1;
    send_wait(8'd0, 26);
    bus(1'b0, 8'h10, 32'h0);
    chk(rd === 32'd26, "in count");
    bus(1'b0, 8'h14, 32'h0);
    chk(rd === 32'd26, "out count");
    summarize();
  end
endmodule // tb_top
